// *** hw/dsa_regs.svh ***
// Timing counts and sizes for the strobe-sequenced dynamic memory controller.
// Assumes a 100 ns controller clock; all counts derive from the times below.
`ifndef DSA_REGS_SVH
`define DSA_REGS_SVH

`define DSA_CLK_NS 100
`define DSA_ROWS 128
`define DSA_INIT_REFS 4'h8
// Least times in ns, rounded up to whole cycles
`define DSA_T_RAH_NS 25
`define DSA_T_RAS_NS 200
`define DSA_T_RP_NS 120
`define DSA_T_CAC_NS 135
`define DSA_T_CWL_NS 80
`define DSA_RAH_CYC ((`DSA_T_RAH_NS + `DSA_CLK_NS - 1) / `DSA_CLK_NS)
`define DSA_RAS_CYC ((`DSA_T_RAS_NS + `DSA_CLK_NS - 1) / `DSA_CLK_NS)
`define DSA_RP_CYC ((`DSA_T_RP_NS + `DSA_CLK_NS - 1) / `DSA_CLK_NS)
`define DSA_CAC_CYC ((`DSA_T_CAC_NS + `DSA_CLK_NS - 1) / `DSA_CLK_NS)
`define DSA_CWL_CYC ((`DSA_T_CWL_NS + `DSA_CLK_NS - 1) / `DSA_CLK_NS)
// Refresh period in ns spread over all rows, rounded down
`define DSA_T_REF_NS 2000000
`define DSA_REF_CYC (`DSA_T_REF_NS / `DSA_ROWS / `DSA_CLK_NS)

`endif

// *** hw/dsa_pkg.sv ***
// Types shared by the dynamic memory controller files.
// Assumes dsa_regs.svh supplies the numeric constants.
package dsa_pkg;

  // Access kinds a user may request
  typedef enum logic [1:0] {
    DSA_OP_READ = 2'h0,
    DSA_OP_EARLY_WR = 2'h1,
    DSA_OP_DELAY_WR = 2'h2
  } dsa_op_e;

  // One user request: high seven address bits are the row
  typedef struct packed {
    dsa_op_e op;
    logic [13:0] addr;
    logic wdata;
  } dsa_req_s;

  // Pins driven toward the memory device
  typedef struct packed {
    logic ras_n;
    logic cas_n;
    logic write_n;
    logic [6:0] muxed_address_pins;
    logic din;
  } dsa_pins_s;

  // Sequencer states, one-hot
  typedef enum logic [8:0] {
    DSA_ST_IDLE = 9'h001,
    DSA_ST_ASR = 9'h002,
    DSA_ST_ROW = 9'h004,
    DSA_ST_COL = 9'h008,
    DSA_ST_CAS = 9'h010,
    DSA_ST_WR = 9'h020,
    DSA_ST_OPEN = 9'h040,
    DSA_ST_PRE = 9'h080,
    DSA_ST_REF = 9'h100
  } dsa_state_e;

endpackage

// *** hw/dsa_cnt.sv ***
// Loadable down counter with a zero flag, used for phase and refresh timing.
// Assumes one clock, active-low asynchronous reset and a clock enable.
`timescale 1ns/10ps
module dsa_cnt #(
  parameter int W = 8
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic load_in,
  input wire logic [W-1:0] load_val_in,
  output logic done_out
);

  logic [W-1:0] cnt_q;

  // Zero means the timed interval has elapsed
  assign done_out = (cnt_q == '0);

  // Load wins; otherwise count down to zero and stop
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= '0;
    end else if (ce_in) begin
      if (load_in) begin
        cnt_q <= load_val_in;
      end else if (!done_out) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

endmodule

// *** hw/dsa_ctrl.sv ***
// Controller that drives a 16K x 1 strobe-sequenced dynamic memory.
// Assumes the device data output is sampled synchronously to ref_clk_in.
//
// Behaviour
// R1: Address sent row half first, column second
// R2: Device latches row on row strobe fall
// R3: Device accepts column strobe after row hold
// R4: Late column strobe still works, slower access
// R5: Device latches data on later falling edge
// R6: Early write lowers write before column strobe
// R7: Delayed write lowers write after column strobe
// R8: Reads keep write high while column low
// R9: Device output floats while column strobe high
// R10: Device output valid until column strobe rises
// R11: Device drives cell data at access time
// R12: Early write keeps device output floating
// R13: Either strobe may act as chip select
// R14: All-early-write controller may share data line
// R15: Both strobes may be decoded in grid
// R16: Device cycle kind set by strobe ordering
// R17: Refresh all 128 rows every 2 ms
// R18: Eight refresh cycles before normal use
// R19: Device acts only with both strobes
// R20: Page mode holds row strobe, pulses column
// R21: Row-only cycle refreshes without data output
`timescale 1ns/10ps
`include "dsa_regs.svh"
module dsa_ctrl (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic req_valid_in,
  input wire dsa_pkg::dsa_req_s req_in,
  input wire logic page_en_in,
  input wire logic dram_dout_in,
  output logic req_ready_out,
  output logic rsp_valid_out,
  output logic rsp_data_out,
  output logic init_done_out,
  output dsa_pkg::dsa_pins_s pins_out
);

  dsa_pkg::dsa_state_e state_q, state_d;
  dsa_pkg::dsa_pins_s pins_q, pins_d;
  dsa_pkg::dsa_req_s cur_q, cur_d;
  logic ready_q, ready_d;
  logic rsp_valid_q, rsp_valid_d;
  logic rsp_data_q, rsp_data_d;
  logic init_q, init_d;
  logic is_ref_q, is_ref_d;
  logic have_q, have_d;
  logic ref_pend_q, ref_pend_d;
  logic [6:0] refrow_q, refrow_d;
  logic [3:0] init_cnt_q, init_cnt_d;
  logic ph_load;
  logic [7:0] ph_val;
  logic ph_done;
  logic ref_tick;
  logic ref_clear;

  // Request decode
  wire take_w = ready_q && req_valid_in;
  wire same_row_w = (req_in.addr[13:7] == cur_q.addr[13:7]);
  wire is_early_w = (cur_q.op == dsa_pkg::DSA_OP_EARLY_WR);
  wire is_delay_w = (cur_q.op == dsa_pkg::DSA_OP_DELAY_WR);
  wire is_read_w = (cur_q.op == dsa_pkg::DSA_OP_READ);
  wire init_full_w = (init_cnt_q == `DSA_INIT_REFS);
  wire [6:0] row_w = req_in.addr[13:7];

  // Phase timer: loaded on entry to each timed state
  dsa_cnt #(.W(8)) u_phase (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .load_in(ph_load),
    .load_val_in(ph_val),
    .done_out(ph_done)
  );

  // Refresh interval timer, reloads itself on each tick
  dsa_cnt #(.W(8)) u_refresh (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .load_in(ref_tick),
    .load_val_in(8'(`DSA_REF_CYC - 1)),
    .done_out(ref_tick)
  );

  // Pending refresh: a new tick wins over the clear
  assign ref_pend_d = ref_tick | (ref_pend_q & ~ref_clear); // [R17]

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    pins_d = pins_q;
    cur_d = cur_q;
    ready_d = ready_q;
    rsp_valid_d = 1'b0;
    rsp_data_d = rsp_data_q;
    is_ref_d = is_ref_q;
    have_d = have_q;
    refrow_d = refrow_q;
    init_cnt_d = init_cnt_q;
    ref_clear = 1'b0;
    ph_load = 1'b0;
    ph_val = 8'h00;
    case (state_q)
      dsa_pkg::DSA_ST_IDLE: begin
        if (take_w) begin
          cur_d = req_in;
          ready_d = 1'b0;
          is_ref_d = 1'b0;
          pins_d.muxed_address_pins = row_w; // [R1]
          state_d = dsa_pkg::DSA_ST_ASR;
        end else if (!init_full_w || ref_pend_q) begin
          ready_d = 1'b0;
          is_ref_d = 1'b1;
          pins_d.muxed_address_pins = refrow_q; // [R17] [R18]
          state_d = dsa_pkg::DSA_ST_ASR;
        end else begin
          ready_d = 1'b1;
        end
      end
      dsa_pkg::DSA_ST_ASR: begin
        // Row address has had a cycle of setup; drop the row strobe
        pins_d.ras_n = 1'b0;
        ph_load = 1'b1;
        if (is_ref_q) begin
          ph_val = 8'(`DSA_RAS_CYC - 1);
          state_d = dsa_pkg::DSA_ST_REF;
        end else begin
          ph_val = 8'(`DSA_RAH_CYC - 1);
          state_d = dsa_pkg::DSA_ST_ROW;
        end
      end
      dsa_pkg::DSA_ST_ROW: begin
        if (ph_done) begin
          pins_d.muxed_address_pins = cur_q.addr[6:0]; // [R1]
          pins_d.write_n = ~is_early_w; // [R6] [R8]
          pins_d.din = cur_q.wdata;
          state_d = dsa_pkg::DSA_ST_COL;
        end
      end
      dsa_pkg::DSA_ST_COL: begin
        pins_d.cas_n = 1'b0; // [R1]
        ph_load = 1'b1;
        ph_val = 8'(`DSA_CAC_CYC - 1);
        state_d = dsa_pkg::DSA_ST_CAS;
      end
      dsa_pkg::DSA_ST_CAS: begin
        if (ph_done) begin
          if (!is_early_w) begin
            rsp_data_d = dram_dout_in;
          end
          if (is_delay_w) begin
            pins_d.write_n = 1'b0; // [R7]
            ph_load = 1'b1;
            ph_val = 8'(`DSA_CWL_CYC - 1);
            state_d = dsa_pkg::DSA_ST_WR;
          end else begin
            pins_d.cas_n = 1'b1;
            pins_d.write_n = 1'b1;
            rsp_valid_d = 1'b1;
            if (page_en_in && !ref_pend_q) begin
              ready_d = 1'b1;
              state_d = dsa_pkg::DSA_ST_OPEN; // [R20]
            end else begin
              pins_d.ras_n = 1'b1;
              ph_load = 1'b1;
              ph_val = 8'(`DSA_RP_CYC - 1);
              state_d = dsa_pkg::DSA_ST_PRE;
            end
          end
        end
      end
      dsa_pkg::DSA_ST_WR: begin
        if (ph_done) begin
          pins_d.cas_n = 1'b1;
          pins_d.write_n = 1'b1;
          rsp_valid_d = 1'b1;
          if (page_en_in && !ref_pend_q) begin
            ready_d = 1'b1;
            state_d = dsa_pkg::DSA_ST_OPEN;
          end else begin
            pins_d.ras_n = 1'b1;
            ph_load = 1'b1;
            ph_val = 8'(`DSA_RP_CYC - 1);
            state_d = dsa_pkg::DSA_ST_PRE;
          end
        end
      end
      dsa_pkg::DSA_ST_OPEN: begin
        // Row stays open one cycle for a same-row follow-on
        ready_d = 1'b0;
        if (take_w && same_row_w) begin
          cur_d = req_in;
          pins_d.muxed_address_pins = req_in.addr[6:0]; // [R20]
          pins_d.write_n = ~(req_in.op == dsa_pkg::DSA_OP_EARLY_WR);
          pins_d.din = req_in.wdata;
          state_d = dsa_pkg::DSA_ST_COL;
        end else begin
          if (take_w) begin
            cur_d = req_in;
            have_d = 1'b1;
          end
          pins_d.ras_n = 1'b1;
          ph_load = 1'b1;
          ph_val = 8'(`DSA_RP_CYC - 1);
          state_d = dsa_pkg::DSA_ST_PRE;
        end
      end
      dsa_pkg::DSA_ST_PRE: begin
        if (ph_done) begin
          if (have_q) begin
            have_d = 1'b0;
            is_ref_d = 1'b0;
            pins_d.muxed_address_pins = cur_q.addr[13:7];
            state_d = dsa_pkg::DSA_ST_ASR;
          end else begin
            ready_d = init_full_w && !ref_pend_q;
            state_d = dsa_pkg::DSA_ST_IDLE;
          end
        end
      end
      dsa_pkg::DSA_ST_REF: begin
        // Row-only refresh: column strobe never falls
        if (ph_done) begin
          pins_d.ras_n = 1'b1;
          refrow_d = refrow_q + 7'h01; // [R17]
          if (!init_full_w) begin
            init_cnt_d = init_cnt_q + 4'h1; // [R18]
          end
          ref_clear = 1'b1;
          ph_load = 1'b1;
          ph_val = 8'(`DSA_RP_CYC - 1);
          state_d = dsa_pkg::DSA_ST_PRE;
        end
      end
      default: begin
        state_d = dsa_pkg::DSA_ST_IDLE;
        ready_d = 1'b0;
      end
    endcase
  end

  assign init_d = init_full_w;

  // State registers, frozen while the clock enable is low
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= dsa_pkg::DSA_ST_IDLE;
      pins_q <= {1'b1, 1'b1, 1'b1, 7'h00, 1'b0};
      cur_q <= '0;
      ready_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_data_q <= 1'b0;
      init_q <= 1'b0;
      is_ref_q <= 1'b0;
      have_q <= 1'b0;
      ref_pend_q <= 1'b0;
      refrow_q <= 7'h00;
      init_cnt_q <= 4'h0;
    end else if (ce_in) begin
      state_q <= state_d;
      pins_q <= pins_d;
      cur_q <= cur_d;
      ready_q <= ready_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_data_q <= rsp_data_d;
      init_q <= init_d;
      is_ref_q <= is_ref_d;
      have_q <= have_d;
      ref_pend_q <= ref_pend_d;
      refrow_q <= refrow_d;
      init_cnt_q <= init_cnt_d;
    end
  end

  assign pins_out = pins_q; // Separate data pins, one device, no strobe decode [R14] [R15]
  assign req_ready_out = ready_q;
  assign rsp_valid_out = rsp_valid_q;
  assign rsp_data_out = rsp_data_q;
  assign init_done_out = init_q;

  // Cycles since the last row-only refresh ended its DSA_ST_REF phase, saturating
  localparam int GAP_MAX = `DSA_REF_CYC + 24;
  logic [8:0] gap_q;
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gap_q <= 9'h000;
    end else if (ce_in) begin
      gap_q <= (state_q == dsa_pkg::DSA_ST_REF) ? 9'h000 : gap_q + {8'h00, ~&gap_q};
    end
  end

  default clocking dsa_cb @(posedge ref_clk_in iff ce_in);
  endclocking
  default disable iff (!rst_n_in);

  a_row_before_col: assert property ($fell(pins_q.cas_n) |-> !pins_q.ras_n && $past(!pins_q.ras_n)) // [R1]
    else $error("column strobe fell without row strobe held low");
  a_row_addr_half: assert property ($fell(pins_q.ras_n) && !is_ref_q
      |-> pins_q.muxed_address_pins == cur_q.addr[13:7]) // [R1]
    else $error("row strobe fell with wrong row half");
  a_col_addr_half: assert property ($fell(pins_q.cas_n)
      |-> pins_q.muxed_address_pins == cur_q.addr[6:0]) // [R1]
    else $error("column strobe fell with wrong column half");
  a_early_write_lead: assert property ($fell(pins_q.cas_n) && is_early_w
      |-> !pins_q.write_n && $past(!pins_q.write_n)) // [R6]
    else $error("early write line not low before column strobe");
  a_delayed_write_lag: assert property ($fell(pins_q.write_n) && !pins_q.cas_n
      |-> $past(!pins_q.cas_n, 2) && is_delay_w) // [R7]
    else $error("delayed write fell too soon after column strobe");
  a_write_data_held: assert property ($fell(pins_q.write_n) ##0 !pins_q.cas_n
      |-> pins_q.din == cur_q.wdata) // [R7]
    else $error("write data not presented at write edge");
  a_read_write_high: assert property (!pins_q.cas_n && is_read_w |-> pins_q.write_n) // [R8]
    else $error("write line low during read column phase");
  a_refresh_gap: assert property (init_q |-> gap_q <= GAP_MAX) // [R17]
    else $error("refresh interval exceeded");
  a_init_refresh: assert property (ready_q |-> init_cnt_q == `DSA_INIT_REFS) // [R18]
    else $error("request accepted before eight refresh cycles");
  a_page_row_open: assert property (state_q == dsa_pkg::DSA_ST_OPEN
      |-> !pins_q.ras_n && pins_q.cas_n ##1 (pins_q.ras_n || !pins_q.cas_n || state_q == dsa_pkg::DSA_ST_COL)) // [R20]
    else $error("page gap without row strobe held");

endmodule

// *** testbench/dsa_dev_model.sv ***
// Behavioural model of the 16K x 1 strobe-sequenced memory device.
// Assumes registered strobes from the controller; its data out is fed back unsynchronised.
`timescale 1ns/10ps
module dsa_dev_model (
  input wire dsa_pkg::dsa_pins_s pins_in,
  output logic dout_out
);
  logic mem [0:16383];
  logic [6:0] row_q;
  logic [6:0] col_q;
  logic drive_q = 1'b0;
  logic data_q = 1'b0;
  logic last_q = 1'b0;
  logic early_q = 1'b0;
  logic cas_seen_q = 1'b1;
  int ras_cnt = 0;
  int ras_only_cnt = 0;
  int wr_cnt = 0;
  realtime row_ts [0:127];

  // Fill cells with a pattern so reads before writes are defined
  initial begin
    for (int i = 0; i < 16384; i++) begin
      mem[i] = i[0] ^ i[7];
    end
    for (int r = 0; r < 128; r++) begin
      row_ts[r] = 0.0;
    end
  end

  // Row latch on row strobe fall; every fall refreshes that row
  always @(negedge pins_in.ras_n) begin
    row_q = pins_in.muxed_address_pins;
    row_ts[row_q] = $realtime;
    ras_cnt++;
    cas_seen_q = 1'b0;
  end

  // Row-only cycle is counted and touches no cell
  always @(posedge pins_in.ras_n) begin
    if (!cas_seen_q) ras_only_cnt++;
  end

  // Column latch; early write stores, otherwise cell data is driven out
  always @(negedge pins_in.cas_n) begin
    if (!pins_in.ras_n) begin
      col_q = pins_in.muxed_address_pins;
      cas_seen_q = 1'b1;
      early_q = !pins_in.write_n;
      if (early_q) begin
        mem[{row_q, col_q}] = pins_in.din;
        wr_cnt++;
      end else begin
        data_q = mem[{row_q, col_q}];
        drive_q = 1'b1;
      end
    end
  end

  // Delayed write: data strobed by the later write fall
  always @(negedge pins_in.write_n) begin
    if (!pins_in.ras_n && !pins_in.cas_n && !early_q) begin
      mem[{row_q, col_q}] = pins_in.din;
      wr_cnt++;
    end
  end

  // Output released when the column strobe rises, whatever the row strobe does
  always @(posedge pins_in.cas_n) begin
    if (drive_q) last_q = data_q;
    drive_q = 1'b0;
  end

  // A floating line shows the inverse of the last driven value
  assign dout_out = drive_q ? data_q : ~last_q;
endmodule

// *** testbench/tb.sv ***
// Self-checking bench for the dynamic memory controller with a device model.
// Assumes dsa_pkg and the design files are compiled first.
`timescale 1ns/10ps
module tb;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic ce_in = 1'b0;
  logic req_valid_in = 1'b0;
  logic page_en_in = 1'b0;
  dsa_pkg::dsa_req_s req_in = '0;
  logic dram_dout;
  logic req_ready_out;
  logic rsp_valid_out;
  logic rsp_data_out;
  logic init_done_out;
  dsa_pkg::dsa_pins_s pins_out;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;
  logic rsp_q [$];
  logic d;
  int w0;
  int r0;

  dsa_ctrl dut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
    .req_valid_in(req_valid_in), .req_in(req_in), .page_en_in(page_en_in),
    .dram_dout_in(dram_dout), .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
    .rsp_data_out(rsp_data_out), .init_done_out(init_done_out), .pins_out(pins_out));
  dsa_dev_model dev (.pins_in(pins_out), .dout_out(dram_dout));

  // Clock and run ceiling
  initial forever #50 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      $display("[FAIL] %0t run ceiling reached", $time);
      close_out();
    end
  end
  // Responses collected mid-cycle where they are settled
  always @(negedge ref_clk_in) begin
    if (rsp_valid_out === 1'b1) rsp_q.push_back(rsp_data_out);
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  // Present a request and hold it until the take edge; keep leaves valid up.
  // The page choice is applied at the take edge so it governs this access only.
  task automatic send(input dsa_pkg::dsa_op_e op, input logic [13:0] a, input logic wd,
                      input logic pg, input bit keep);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    req_valid_in <= 1'b1;
    req_in <= '{op: op, addr: a, wdata: wd};
    do begin
      @(negedge ref_clk_in);
      n++;
    end while (req_ready_out !== 1'b1 && n < 300);
    check(n < 300, 1, "request not taken");
    @(posedge ref_clk_in);
    page_en_in <= pg;
    if (!keep) req_valid_in <= 1'b0;
  endtask

  task automatic get_rsp(output logic v);
    int n;
    n = 0;
    while (rsp_q.size() == 0 && n < 100) begin
      @(negedge ref_clk_in);
      n++;
    end
    check(n < 100, 1, "no response");
    if (rsp_q.size() > 0) begin
      v = rsp_q.pop_front();
    end else begin
      v = 1'bx;
    end
  endtask

  // Power-up refreshes, no column activity, then ready
  task automatic t_init();
    int n;
    n = 0;
    while (req_ready_out !== 1'b1 && n < 300) begin
      @(negedge ref_clk_in);
      n++;
    end
    check(init_done_out, 1'b1, "init done");
    check(dev.ras_only_cnt >= 8, 1, "power-up refreshes");
    check(dev.wr_cnt, 0, "cells written during init");
  endtask

  // Early writes then reads at both end addresses and two patterned ones
  task automatic t_write_read();
    logic [13:0] tbl [4];
    tbl = '{14'h0000, 14'h3FFF, 14'h2A55, 14'h1580};
    for (int i = 0; i < 4; i++) begin
      send(dsa_pkg::DSA_OP_EARLY_WR, tbl[i], i[0] ^ 1'b1, 1'b0, 1'b0);
      get_rsp(d);
      check(dev.mem[tbl[i]], i[0] ^ 1'b1, "cell after early write");
      check({dev.row_q, dev.col_q}, tbl[i], "latched address");
      w0 = dev.wr_cnt;
      send(dsa_pkg::DSA_OP_READ, tbl[i], 1'b0, 1'b0, 1'b0);
      get_rsp(d);
      check(d, i[0] ^ 1'b1, "read data");
      check(dev.wr_cnt, w0, "write during read");
    end
  endtask

  // Delayed write returns old data and stores the new bit
  task automatic t_rmw();
    send(dsa_pkg::DSA_OP_EARLY_WR, 14'h0C3A, 1'b0, 1'b0, 1'b0);
    get_rsp(d);
    send(dsa_pkg::DSA_OP_DELAY_WR, 14'h0C3A, 1'b1, 1'b0, 1'b0);
    get_rsp(d);
    check(d, 1'b0, "old data from delayed write");
    check(dev.mem[14'h0C3A], 1'b1, "cell after delayed write");
  endtask

  // Page follow-on in the same row, then one that must reopen another row
  task automatic t_page();
    send(dsa_pkg::DSA_OP_EARLY_WR, 14'h1A05, 1'b1, 1'b0, 1'b0);
    get_rsp(d);
    r0 = dev.ras_cnt;
    send(dsa_pkg::DSA_OP_EARLY_WR, 14'h1A11, 1'b0, 1'b1, 1'b1);
    send(dsa_pkg::DSA_OP_READ, 14'h1A05, 1'b0, 1'b0, 1'b0);
    get_rsp(d);
    get_rsp(d);
    check(d, 1'b1, "page read data");
    check(dev.ras_cnt - r0, 1, "row strobe falls in page");
    check(dev.mem[14'h1A11], 1'b0, "page write cell");
    send(dsa_pkg::DSA_OP_READ, 14'h1A11, 1'b0, 1'b1, 1'b1);
    send(dsa_pkg::DSA_OP_READ, 14'h0C3A, 1'b0, 1'b0, 1'b0);
    get_rsp(d);
    check(d, 1'b0, "page read before row change");
    get_rsp(d);
    check(d, 1'b1, "read after row change");
    check(dev.ras_cnt - r0, 3, "row strobe falls after row change");
  endtask

  // Idle for over 2 ms: every row refreshed in time, no cell touched
  task automatic t_refresh();
    int stale;
    stale = 0;
    w0 = dev.wr_cnt;
    repeat (20500) @(posedge ref_clk_in);
    for (int r = 0; r < 128; r++) begin
      if ($realtime - dev.row_ts[r] > 2000000.0) stale++;
    end
    check(stale, 0, "rows not refreshed");
    check(dev.wr_cnt, w0, "cells written by refresh");
    send(dsa_pkg::DSA_OP_READ, 14'h3FFF, 1'b0, 1'b0, 1'b0);
    get_rsp(d);
    check(d, 1'b0, "data kept over refresh");
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Reset, then the scenarios in turn
  initial begin
    repeat (10) @(posedge ref_clk_in);
    check({pins_out.ras_n, pins_out.cas_n, pins_out.write_n}, 3'h7, "strobes in reset");
    repeat (10) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    ce_in <= 1'b1;
    t_init();
    t_write_read();
    t_rmw();
    t_page();
    t_refresh();
    close_out();
  end
endmodule
